// [rtl/tsc_pkg.sv]
package tsc_pkg;
    // clock and sample timebase
    localparam int CLK_PERIOD_NS = 20;
    localparam int SAMPLE_PERIOD_NS = 1300;
    localparam logic [15:0] TIMER_RESET = 16'(SAMPLE_PERIOD_NS / CLK_PERIOD_NS);

    // sizes
    localparam int NUM_CH = 4;
    localparam int NUM_LINES = 8;
    localparam int SAMPLE_W = 16;
    localparam int COUNT_W = 24;
    localparam int NUM_SRC = 17;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_POST = 8'h08;
    localparam logic [7:0] ADDR_TIMER = 8'h0C;
    localparam logic [7:0] ADDR_DRIVE = 8'h10;
    localparam logic [7:0] ADDR_SAMPSEL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [3:0] ADDR_LEVEL_HI = 4'h2;

    // control register fields
    localparam int CTRL_SRC_A_LSB = 0;
    localparam int CTRL_SRC_B_LSB = 5;
    localparam int CTRL_SLOPE_A = 10;
    localparam int CTRL_SLOPE_B = 11;
    localparam int CTRL_ROLE_LSB = 12;
    localparam int CTRL_PAIR_LSB = 14;

    // command bits, write-only strobes
    localparam int CMD_INIT = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_BUS = 2;

    // drive and sample-select fields
    localparam int DRIVE_SRC_LSB = 8;
    localparam int SAMPSEL_LINE_LSB = 1;

    // event source codes
    localparam logic [4:0] SRC_OFF = 5'h00;
    localparam logic [4:0] SRC_BUS = 5'h01;
    localparam logic [4:0] SRC_EXT = 5'h02;
    localparam logic [4:0] SRC_HOLD = 5'h03;
    localparam logic [4:0] SRC_IMM = 5'h04;
    localparam logic [4:0] SRC_LVL_BASE = 5'h05;
    localparam logic [4:0] SRC_LINE_BASE = 5'h09;
    localparam logic [4:0] SRC_LINE_LAST = 5'h10;

    // sync roles
    localparam logic [1:0] ROLE_STD = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE = 2'h2;

    // reset values
    localparam logic [COUNT_W-1:0] POST_RESET = 24'h000001;
    localparam logic [SAMPLE_W-1:0] LEVEL_RESET = 16'h8000;
    localparam logic [7:0] DRIVE_EN_RESET = 8'h00;
    localparam logic [7:0] DRIVE_SRC_RESET = 8'hFF;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_POST = 4'h4,
        ST_DONE = 4'h8
    } tsc_state_t;
endpackage

// [rtl/tsc_evt_if.sv]
`timescale 1ns/1ps
// candidate trigger events shared by both source selectors
interface tsc_evt_if;
    logic [tsc_pkg::NUM_SRC-1:0] evt;
    logic ext_rise;
    logic ext_fall;
    modport prov (output evt, output ext_rise, output ext_fall);
    modport sel (input evt, input ext_rise, input ext_fall);
endinterface

// [rtl/tsc_src_sel.sv]
`timescale 1ns/1ps
// one event source selector: picks one candidate event by code
module tsc_src_sel (
    input wire logic [4:0] code_in,
    input wire logic slope_neg_in,
    input wire logic [7:0] block_in,
    tsc_evt_if.sel ev,
    output logic hit_out
);
    wire is_line;
    wire [4:0] line_off;
    wire line_blocked;
    wire in_range;

    // line codes map onto backplane lines 0..7
    assign is_line = (code_in >= tsc_pkg::SRC_LINE_BASE) && (code_in <= tsc_pkg::SRC_LINE_LAST);
    assign line_off = code_in - tsc_pkg::SRC_LINE_BASE;
    assign line_blocked = is_line && block_in[line_off[2:0]];
    assign in_range = code_in <= tsc_pkg::SRC_LINE_LAST;

    // outside event edge follows the per-source polarity
    assign hit_out = (code_in == tsc_pkg::SRC_EXT) ? (slope_neg_in ? ev.ext_fall : ev.ext_rise)
                   : (line_blocked || !in_range) ? 1'b0
                   : ev.evt[code_in];
endmodule

// [rtl/tsc_trigger_sync.sv]
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tsc_trigger_sync (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [tsc_pkg::NUM_CH-1:0][tsc_pkg::SAMPLE_W-1:0] ch_data_in,
    input wire logic ch_valid_in,
    input wire logic outside_event_input_in,
    input wire logic [7:0] line_in,
    output logic [7:0] line_out,
    output logic [7:0] line_oe_out,
    output logic trigger_out,
    output logic take_reading_out,
    output logic sample_tick_out,
    output logic acq_busy_out
);
    // configuration registers
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic slope_a;
    logic slope_b;
    logic [1:0] role;
    logic [1:0] pair;
    logic [tsc_pkg::COUNT_W-1:0] post_cnt;
    logic [15:0] timer_per;
    logic [7:0] drv_en;
    logic [7:0] drv_src;
    logic samp_from_line;
    logic [2:0] samp_line;
    logic [tsc_pkg::SAMPLE_W-1:0] level [tsc_pkg::NUM_CH];
    // bus data phase
    logic wr_pend;
    logic [7:0] wr_addr;
    // synchronisers and live state
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic [tsc_pkg::NUM_CH-1:0] lvl_hit;
    logic [15:0] tmr;
    logic trig_hold;
    logic [tsc_pkg::COUNT_W-1:0] remaining;
    logic [tsc_pkg::COUNT_W-1:0] taken;
    tsc_pkg::tsc_state_t state;
    tsc_pkg::tsc_state_t next_state;

    wire addr_ok;
    wire [7:0] ra;
    wire [31:0] ctrl_rd;
    wire [31:0] rd_word;
    wire we_ctrl;
    wire we_cmd;
    wire we_post;
    wire we_timer;
    wire we_drive;
    wire we_sampsel;
    wire cmd_init;
    wire cmd_abort;
    wire cmd_bus;
    wire [7:0] line_rise;
    wire ext_rise;
    wire ext_fall;
    wire in_role;
    wire is_master;
    wire is_slave;
    wire [2:0] pair_n;
    wire [2:0] trig_line;
    wire [4:0] eff_a;
    wire [7:0] block_b;
    wire hit_a;
    wire hit_b;
    wire armed;
    wire trig_accept;
    wire local_fire;
    wire timer_tick;
    wire sample_level;
    wire line_mode;
    wire [2:0] sel_line;
    wire sample_tick;
    wire take_now;

    tsc_evt_if evt_bus ();

    // single-cycle slave: never waits, never errors
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign addr_ok = hsel_in && htrans_in[1] && hready_in;
    assign ra = haddr_in[7:0];

    // address phase is held for the write data phase
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite_in;
            wr_addr <= ra;
        end
    end

    // write decode in the data phase
    assign we_ctrl = wr_pend && (wr_addr == tsc_pkg::ADDR_CTRL);
    assign we_cmd = wr_pend && (wr_addr == tsc_pkg::ADDR_CMD);
    assign we_post = wr_pend && (wr_addr == tsc_pkg::ADDR_POST);
    assign we_timer = wr_pend && (wr_addr == tsc_pkg::ADDR_TIMER);
    assign we_drive = wr_pend && (wr_addr == tsc_pkg::ADDR_DRIVE);
    assign we_sampsel = wr_pend && (wr_addr == tsc_pkg::ADDR_SAMPSEL);
    assign cmd_init = we_cmd && hwdata_in[tsc_pkg::CMD_INIT];
    assign cmd_abort = we_cmd && hwdata_in[tsc_pkg::CMD_ABORT];
    assign cmd_bus = we_cmd && hwdata_in[tsc_pkg::CMD_BUS];

    // readback shows programmed sources, never the values a role forces
    assign ctrl_rd = {16'h0000, pair, role, slope_b, slope_a, src_b, src_a};
    assign rd_word = (ra == tsc_pkg::ADDR_CTRL) ? ctrl_rd
                   : (ra == tsc_pkg::ADDR_POST) ? {8'h00, post_cnt}
                   : (ra == tsc_pkg::ADDR_TIMER) ? {16'h0000, timer_per}
                   : (ra == tsc_pkg::ADDR_DRIVE) ? {16'h0000, drv_src, drv_en}
                   : (ra == tsc_pkg::ADDR_SAMPSEL) ? {28'h0000000, samp_line, samp_from_line}
                   : (ra == tsc_pkg::ADDR_STATUS) ? {remaining, 3'h0, trig_hold, 4'(state)}
                   : (ra[7:4] == tsc_pkg::ADDR_LEVEL_HI) ? {16'h0000, level[ra[3:2]]}
                   : 32'h00000000;

    // read data registered at the address phase, valid in the data phase
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            hrdata_out <= 32'h00000000;
        end else if (addr_ok && !hwrite_in) begin
            hrdata_out <= rd_word;
        end
    end

    // configuration writes; reset state follows power-on defaults
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            src_a <= tsc_pkg::SRC_IMM;
            src_b <= tsc_pkg::SRC_HOLD;
            slope_a <= 1'b0;
            slope_b <= 1'b0;
            role <= tsc_pkg::ROLE_STD;
            pair <= 2'h0;
            post_cnt <= tsc_pkg::POST_RESET;
            timer_per <= tsc_pkg::TIMER_RESET;
            drv_en <= tsc_pkg::DRIVE_EN_RESET;
            drv_src <= tsc_pkg::DRIVE_SRC_RESET;
            samp_from_line <= 1'b0;
            samp_line <= 3'h0;
        end else begin
            if (we_ctrl) begin
                src_a <= hwdata_in[tsc_pkg::CTRL_SRC_A_LSB +: 5];
                src_b <= hwdata_in[tsc_pkg::CTRL_SRC_B_LSB +: 5];
                slope_a <= hwdata_in[tsc_pkg::CTRL_SLOPE_A];
                slope_b <= hwdata_in[tsc_pkg::CTRL_SLOPE_B];
                role <= hwdata_in[tsc_pkg::CTRL_ROLE_LSB +: 2];
                pair <= hwdata_in[tsc_pkg::CTRL_PAIR_LSB +: 2];
            end
            if (we_post) begin
                post_cnt <= hwdata_in[tsc_pkg::COUNT_W-1:0];
            end
            if (we_timer) begin
                timer_per <= hwdata_in[15:0];
            end
            if (we_drive) begin
                drv_en <= hwdata_in[7:0];
                drv_src <= hwdata_in[tsc_pkg::DRIVE_SRC_LSB +: 8];
            end
            if (we_sampsel) begin
                samp_from_line <= hwdata_in[0];
                samp_line <= hwdata_in[tsc_pkg::SAMPSEL_LINE_LSB +: 3];
            end
        end
    end

    // pins arrive asynchronously; only stage two and three feed edge logic
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sync1 <= 9'h000;
            sync2 <= 9'h000;
            sync3 <= 9'h000;
        end else begin
            sync1 <= {outside_event_input_in, line_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    assign line_rise = sync2[7:0] & ~sync3[7:0];
    assign ext_rise = sync2[8] && !sync3[8];
    assign ext_fall = !sync2[8] && sync3[8];

    // per-channel threshold registers and comparators
    genvar k;
    generate
        for (k = 0; k < tsc_pkg::NUM_CH; k++) begin : g_ch
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    level[k] <= tsc_pkg::LEVEL_RESET;
                    lvl_hit[k] <= 1'b0;
                end else begin
                    if (wr_pend && wr_addr == {tsc_pkg::ADDR_LEVEL_HI, 2'(k), 2'h0}) begin
                        level[k] <= hwdata_in[tsc_pkg::SAMPLE_W-1:0];
                    end
                    // judged only on real samples, so the hit value may overshoot
                    lvl_hit[k] <= ch_valid_in && ($signed(ch_data_in[k]) >= $signed(level[k]));
                end
            end
            AST_LEVEL_HIT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
                ch_valid_in && ($signed(ch_data_in[k]) >= $signed(level[k])) |=> lvl_hit[k])
                else $error("level hit missed on a sample at or above threshold");
            AST_LEVEL_QUIET: assert property (@(posedge clk_sys_in) disable iff (srst_in)
                !ch_valid_in || ($signed(ch_data_in[k]) < $signed(level[k])) |=> !lvl_hit[k])
                else $error("level hit without a qualifying sample");
        end
    endgenerate

    // candidate events, indexed by source code
    assign evt_bus.evt = {line_rise, lvl_hit, 1'b1, 1'b0, 1'b0, cmd_bus, 1'b0};
    assign evt_bus.ext_rise = ext_rise;
    assign evt_bus.ext_fall = ext_fall;

    // roles pair line n (sample) with line n+1 (trigger)
    assign in_role = role != tsc_pkg::ROLE_STD;
    assign is_master = role == tsc_pkg::ROLE_MASTER;
    assign is_slave = role == tsc_pkg::ROLE_SLAVE;
    assign pair_n = {pair, 1'b0};
    assign trig_line = {pair, 1'b1};
    assign eff_a = in_role ? (tsc_pkg::SRC_LINE_BASE + {2'h0, trig_line}) : src_a;
    assign block_b = in_role ? (8'h03 << pair_n) : 8'h00;

    tsc_src_sel u_sel_a (
        .code_in(eff_a),
        .slope_neg_in(slope_a),
        .block_in(8'h00),
        .ev(evt_bus.sel),
        .hit_out(hit_a)
    );

    // in a role only source b is free and it feeds the shared trigger line
    tsc_src_sel u_sel_b (
        .code_in(src_b),
        .slope_neg_in(slope_b),
        .block_in(block_b),
        .ev(evt_bus.sel),
        .hit_out(hit_b)
    );

    // in a role every module accepts only the shared line, so all fire alike
    assign armed = state == tsc_pkg::ST_ARMED;
    assign trig_accept = armed && (in_role ? hit_a : (hit_a || hit_b));
    assign local_fire = armed && (in_role ? hit_b : trig_accept);

    // trigger signal level held until the acquisition ends; set wins over clear
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            trig_hold <= 1'b0;
        end else if (local_fire) begin
            trig_hold <= 1'b1;
        end else if (cmd_abort || cmd_init || state == tsc_pkg::ST_DONE) begin
            trig_hold <= 1'b0;
        end
    end

    // internal sample timer; a period of zero or one ticks every cycle
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            tmr <= 16'h0000;
        end else if (tmr == 16'h0000) begin
            tmr <= (timer_per == 16'h0000) ? 16'h0000 : timer_per - 16'h0001;
        end else begin
            tmr <= tmr - 16'h0001;
        end
    end
    assign timer_tick = tmr == 16'h0000;
    assign sample_level = tmr > (timer_per >> 1);

    // master also samples its own line so it stays aligned with slaves
    assign line_mode = in_role || samp_from_line;
    assign sel_line = in_role ? pair_n : samp_line;
    assign sample_tick = line_mode ? line_rise[sel_line] : timer_tick;
    assign take_now = (state == tsc_pkg::ST_POST) && sample_tick && (remaining != '0);

    // line drivers; trigger lines are wired-or, so they drive only while asserted
    genvar i;
    generate
        for (i = 0; i < tsc_pkg::NUM_LINES; i++) begin : g_line
            wire pair_s = in_role && (pair_n == 3'(i));
            wire pair_t = in_role && (trig_line == 3'(i));
            wire want_s = pair_s ? is_master : (!pair_t && drv_en[i] && !drv_src[i]);
            wire want_t = pair_t || (!pair_s && drv_en[i] && drv_src[i]);
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    line_oe_out[i] <= 1'b0;
                    line_out[i] <= 1'b0;
                end else begin
                    line_oe_out[i] <= want_s || (want_t && trig_hold);
                    line_out[i] <= want_s ? sample_level : 1'b1;
                end
            end
        end
    endgenerate

    // acquisition sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            tsc_pkg::ST_IDLE: begin
                if (cmd_init) next_state = tsc_pkg::ST_ARMED;
            end
            tsc_pkg::ST_ARMED: begin
                if (cmd_abort) next_state = tsc_pkg::ST_IDLE;
                else if (trig_accept) next_state = tsc_pkg::ST_POST;
            end
            tsc_pkg::ST_POST: begin
                if (cmd_abort) next_state = tsc_pkg::ST_IDLE;
                else if (remaining == '0) next_state = tsc_pkg::ST_DONE;
            end
            tsc_pkg::ST_DONE: begin
                if (cmd_abort) next_state = tsc_pkg::ST_IDLE;
                else if (cmd_init) next_state = tsc_pkg::ST_ARMED;
            end
            default: next_state = tsc_pkg::ST_IDLE;
        endcase
    end

    // state, reading countdown and registered strobes
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state <= tsc_pkg::ST_IDLE;
            remaining <= '0;
            taken <= '0;
            trigger_out <= 1'b0;
            take_reading_out <= 1'b0;
            sample_tick_out <= 1'b0;
        end else begin
            state <= next_state;
            if (trig_accept) begin
                remaining <= post_cnt;
                taken <= '0;
            end else if (take_now) begin
                remaining <= remaining - 1'b1;
                taken <= taken + 1'b1;
            end
            trigger_out <= trig_accept;
            take_reading_out <= take_now;
            sample_tick_out <= sample_tick;
        end
    end
    assign acq_busy_out = state[1] || state[2];

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    sequence s_armed_std;
        armed && !in_role && !cmd_abort;
    endsequence
    sequence s_entered_done;
        (state == tsc_pkg::ST_POST) ##1 (state == tsc_pkg::ST_DONE);
    endsequence

    AST_RESET_SRC: assert property ($fell(srst_in) |->
        src_a == tsc_pkg::SRC_IMM && src_b == tsc_pkg::SRC_HOLD && role == tsc_pkg::ROLE_STD)
        else $error("sources or role not at reset defaults");
    AST_IMM_FIRES: assert property (s_armed_std and (src_a == tsc_pkg::SRC_IMM) |=>
        state == tsc_pkg::ST_POST && trigger_out)
        else $error("fire at once did not trigger next cycle");
    AST_EXT_EDGE: assert property (s_armed_std and (src_a == tsc_pkg::SRC_EXT)
        and (slope_a ? ext_fall : ext_rise) |=> state == tsc_pkg::ST_POST && trigger_out)
        else $error("outside edge of chosen polarity did not trigger");
    AST_LEVEL_ROUTE: assert property (s_armed_std and (src_a >= tsc_pkg::SRC_LVL_BASE)
        and (src_a < tsc_pkg::SRC_LINE_BASE) and lvl_hit[2'(src_a - tsc_pkg::SRC_LVL_BASE)]
        |=> state == tsc_pkg::ST_POST)
        else $error("selected channel level event did not trigger");
    AST_ONE_TRIG: assert property (trigger_out |=> !trigger_out [*3])
        else $error("second trigger accepted within one acquisition");
    AST_POST_COUNT: assert property (s_entered_done |-> taken == post_cnt)
        else $error("post-trigger reading count mismatch");
    AST_SLAVE_QUIET: assert property (is_slave && $stable(role) && $stable(pair)
        |=> !line_oe_out[pair_n])
        else $error("slave drove the shared sample line");
    AST_MASTER_DRIVE: assert property (is_master && $stable(role) && $stable(pair)
        |=> line_oe_out[pair_n] && (line_oe_out[trig_line] == $past(trig_hold)))
        else $error("master not driving its pair lines");
    AST_SLAVE_SAMPLE: assert property (is_slave && line_rise[pair_n] |=> sample_tick_out)
        else $error("slave not sampling from pair line");
endmodule

// [bench/tsc_peer.sv]
`timescale 1ns/1ps
// another module on the backplane; lines are wired-or, so it only ever pulls high
module tsc_peer (
    input wire logic run_in,
    input wire logic [2:0] pair_line_in,
    input wire logic trig_in,
    output logic [7:0] oe_out
);
    logic sq;
    // sample square at 160 ns, free of the system clock phase; still when not running
    initial begin
        sq = 1'b0;
        #37;
        forever #80 sq = ~sq & run_in;
    end
    // master role: sample on line n; any module may raise the trigger on n+1
    always_comb begin
        oe_out = 8'h00;
        oe_out[pair_line_in] = sq & run_in;
        oe_out[pair_line_in + 3'h1] = trig_in;
    end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    logic clk_sys_in, srst_in, hsel, hwrite, ch_valid, outside_event_input, run, tpulse, hready, hresp;
    logic trig, take, tick, busy;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [tsc_pkg::NUM_CH-1:0][tsc_pkg::SAMPLE_W-1:0] ch_data;
    logic [7:0] lo, loe, poe, wl;
    logic [2:0] pline;
    int errors, cmp_count, cyc, oe_n, nt, nr, ns;
    // released lines fall low; any driver pulls high
    assign wl = (lo & loe) | poe;
    tsc_trigger_sync uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .ch_data_in(ch_data),
        .ch_valid_in(ch_valid), .outside_event_input_in(outside_event_input), .line_in(wl),
        .line_out(lo), .line_oe_out(loe), .trigger_out(trig),
        .take_reading_out(take), .sample_tick_out(tick), .acq_busy_out(busy));
    tsc_peer peer (.run_in(run), .pair_line_in(pline), .trig_in(tpulse), .oe_out(poe));
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // hang guard: the whole run needs under 2000 cycles
    always @(posedge clk_sys_in) begin
        cyc++;
        if (loe[pline] === 1'b1 && run === 1'b1) oe_n++;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // one AHB single: hold address phase until hready, then data phase until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        rv = hrdata;
    endtask
    // count trigger and reading pulses over a window
    task automatic cnt(input int lim);
        nt = 0;
        nr = 0;
        ns = 0;
        repeat (lim) begin
            @(posedge clk_sys_in);
            nt += int'(trig === 1'b1);
            ns += int'(tick === 1'b1);
            nr += int'(take === 1'b1);
        end
    endtask
    task automatic arm_see(input logic [31:0] ctrl, input logic [31:0] c2, input int e);
        bus(1'b1, 8'h00, ctrl);
        bus(1'b1, 8'h04, 32'h00000001);
        if (c2 != 0) bus(1'b1, 8'h04, c2);
        cnt(8);
        chk("trigger count", e, nt);
    endtask
    task automatic samp(input logic [15:0] v);
        ch_data[2] <= v;
        ch_valid <= 1'b1;
        @(posedge clk_sys_in);
        ch_valid <= 1'b0;
    endtask
    initial begin
        {hsel, hwrite, ch_valid, outside_event_input, run, tpulse, htrans, pline} = '0;
        {haddr, hwdata} = '0;
        ch_data = {4{16'h8000}};
        srst_in = 1'b1;
        repeat (8) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h00000064, rv);
        bus(1'b0, 8'h10, 32'h0);
        chk("drive reset", 32'h0000FF00, rv);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h00000000, rv);
        chk("okay response", 0, hresp);
        $display("test reset done");
        bus(1'b1, 8'h08, 32'h00000002);
        bus(1'b1, 8'h04, 32'h00000001);
        cnt(250);
        chk("at once triggers", 1, nt);
        chk("post readings", 2, nr);
        bus(1'b0, 8'h18, 32'h0);
        chk("state done", 32'h8, rv & 32'hF);
        chk("idle when done", 0, busy);
        $display("test at once done");
        bus(1'b1, 8'h28, 32'h00000100);
        arm_see(32'h000000E3, 0, 0);
        chk("busy armed", 1, busy);
        samp(16'h00FF);
        cnt(6);
        chk("below level", 0, nt);
        samp(16'h0100);
        cnt(6);
        chk("at level", 1, nt);
        bus(1'b1, 8'h04, 32'h00000002);
        $display("test level done");
        outside_event_input <= 1'b1;
        arm_see(32'h00000462, 0, 0);
        outside_event_input <= 1'b0;
        cnt(8);
        chk("falling edge", 1, nt);
        bus(1'b1, 8'h04, 32'h00000002);
        arm_see(32'h00000061, 32'h00000004, 1);
        bus(1'b1, 8'h04, 32'h00000002);
        $display("test outside and bus done");
        pline <= 3'h2;
        run <= 1'b1;
        bus(1'b1, 8'h08, 32'h00000001);
        arm_see(32'h00006063, 0, 0);
        tpulse <= 1'b1;
        cnt(12);
        tpulse <= 1'b0;
        chk("slave trigger", 1, nt);
        chk("slave reading", 1, nr);
        cnt(64);
        chk("slave extra reading", 0, nr);
        chk("slave ticks", 8, ns);
        chk("slave sample line", 0, oe_n);
        bus(1'b0, 8'h00, 32'h0);
        chk("slave readback", 32'h00006063, rv);
        run <= 1'b0;
        pline <= 3'h0;
        $display("test slave done");
        arm_see(32'h00001063, 0, 0);
        chk("master sample enable", 1, loe[0]);
        tpulse <= 1'b1;
        cnt(12);
        tpulse <= 1'b0;
        chk("master trigger", 1, nt);
        cnt(6);
        tpulse <= 1'b1;
        cnt(12);
        tpulse <= 1'b0;
        chk("rearm needed", 0, nt);
        bus(1'b0, 8'h00, 32'h0);
        chk("master readback", 32'h00001063, rv);
        $display("test master done");
        finish_test();
    end
endmodule
